// *** hw/ccc_pkg.sv ***
// Constants, register map and carriers for the conversion mode config block.
// Assumes a single 40 MHz reference clock and a serial port driven by a host.
// ============================================================
// Notes on behaviour
// [RULE1] Config register at 17h, resets to 00h
// [RULE2] Bit 3: 0 continuous, 1 single-shot conversion
// [RULE3] Bit 1: 0 comparators off, 1 enabled
// [RULE4] Lead-off status bits ride in data stream
// [RULE5] Host shares data/clock lines, own selects
// [RULE6] One clock master: select pin and enable
// [RULE7] Start synchronizes; start-to-ready latency fixed
// [RULE8] Bias feedback only from selected electrodes
// [RULE9] Deselected device floats its data output
// [RULE10] Single-shot: one conversion per start, halt
package ccc_pkg;
    // ============================================================
    // Register map (5-bit address space)
    localparam logic [4:0] CCC_ADDR_CLK_CTRL = 5'h01; // Clock output control
    localparam logic [4:0] CCC_ADDR_POS_FB = 5'h0D; // positive_feedback_select
    localparam logic [4:0] CCC_ADDR_NEG_FB = 5'h0E; // negative_feedback_select
    localparam logic [4:0] CCC_ADDR_CFG = 5'h17; // conversion_and_comparator_config
    localparam logic [7:0] CCC_CFG_RESET = 8'h00;
    localparam logic [7:0] CCC_FB_RESET = 8'h00;
    localparam logic [7:0] CCC_CLK_CTRL_RESET = 8'h00;
    // Field positions
    localparam int CCC_BIT_SINGLE_SHOT = 3;
    localparam int CCC_BIT_COMP_EN = 1;
    localparam int CCC_BIT_CLK_OUT_EN = 5;
    // ============================================================
    // Serial commands
    localparam logic [7:0] CCC_CMD_SAMPLE = 8'h12; // Read status and samples
    localparam logic [2:0] CCC_OP_READ = 3'h1; // 001a_aaaa
    localparam logic [2:0] CCC_OP_WRITE = 3'h2; // 010a_aaaa
    localparam logic [3:0] CCC_STATUS_TAG = 4'hC; // Leading nibble of status word
    // ============================================================
    // Timing
    localparam int CCC_CLK_PERIOD_PS = 25000; // 40 MHz
    localparam int CCC_CONV_PERIOD_NS = 4000000; // 250 SPS conversion period
    // Divide first so the intermediate value stays inside a 32-bit int
    localparam int CCC_CONV_CYCLES = CCC_CONV_PERIOD_NS / (CCC_CLK_PERIOD_PS / 1000);
    localparam int CCC_SYNC_STAGES = 3;
    // ============================================================
    // Pins arriving from outside the clock domain
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
        logic start;
        logic clk_sel;
        logic [7:0] loff_p;
        logic [7:0] loff_n;
    } ccc_pins_t;
    // Idle pin levels; synchronizers reset to these so no false select follows reset
    localparam ccc_pins_t CCC_PINS_IDLE = '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0, start: 1'b0,
        clk_sel: 1'b0, loff_p: 8'h00, loff_n: 8'h00};
    // Conversion sequencer states, Gray along idle -> convert -> halt
    typedef enum logic [1:0] {
        CCC_ST_IDLE = 2'h0,
        CCC_ST_CONV = 2'h1,
        CCC_ST_HALT = 2'h3
    } ccc_state_t;
endpackage

// *** hw/ccc_pin_sync.sv ***
// Three-stage synchronizer for a bundle of asynchronous pins.
// Assumes every input bit is independent; output moves once stages two and three agree.
`timescale 1ns/1ps
module ccc_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0 // Idle level of each pin, held in reset
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Pins and their clean copy
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] clean_o
);
    // ============================================================
    // Per-bit chains
    generate
        if (WIDTH < 1) begin : g_bad
            $error("ccc_pin_sync: WIDTH must be at least 1");
        end
        for (genvar b = 0; b < WIDTH; b++) begin : g_bit
            logic s1_q, s2_q, s3_q, out_q; // Stage one is read only by stage two
            logic out_d;
            // Next clean value: accept once two and three agree
            always_comb begin
                out_d = (s2_q == s3_q) ? s3_q : out_q;
            end
            // Registers
            always_ff @(posedge ref_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    s1_q <= RST_VAL[b];
                    s2_q <= RST_VAL[b];
                    s3_q <= RST_VAL[b];
                    out_q <= RST_VAL[b];
                end else begin
                    s1_q <= pin_i[b];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    out_q <= out_d;
                end
            end
            assign clean_o[b] = out_q;
        end
    endgenerate
endmodule // ccc_pin_sync

// *** hw/ccc_top.sv ***
// Conversion mode configuration, conversion sequencer and serial port.
// Assumes a host on a shared serial bus with one select per device, and a
// converter core that presents its latest samples on sample_data_i.
`timescale 1ns/1ps
module ccc_top
    import ccc_pkg::*;
#(
    parameter int N_CH = 8, // Channels carried in the data stream
    parameter int SAMPLE_W = 24, // Bits per sample and per status word
    parameter int CONV_CYCLES = CCC_CONV_CYCLES // Clocks per conversion
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Serial port pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    output logic dout_o,
    output logic dout_oe_o,
    // Conversion control pins
    input wire logic start_i,
    input wire logic clock_source_select_pin_i,
    output logic sample_ready_indication_n_o,
    output logic clk_out_en_o,
    // Converter core side
    input wire logic [N_CH*SAMPLE_W-1:0] sample_data_i,
    input wire logic [7:0] loff_comp_p_i,
    input wire logic [7:0] loff_comp_n_i,
    output logic electrode_detach_comparator_enable_o,
    output logic [7:0] positive_feedback_select_o,
    output logic [7:0] negative_feedback_select_o
);
    localparam int FRAME_W = SAMPLE_W * (N_CH + 1);
    // ============================================================
    // Parameter check
    generate
        if (N_CH < 1 || N_CH > 8 || SAMPLE_W != 24 || CONV_CYCLES < 2) begin : g_bad
            $error("ccc_top: unsupported N_CH, SAMPLE_W or CONV_CYCLES");
        end
    endgenerate
    // ============================================================
    // Pin synchronization
    ccc_pins_t raw_pins, pins; // Raw and clean pin bundles
    logic [$bits(ccc_pins_t)-1:0] pins_flat;
    always_comb begin
        raw_pins.sclk = sclk_i;
        raw_pins.cs_n = cs_n_i;
        raw_pins.din = din_i;
        raw_pins.start = start_i;
        raw_pins.clk_sel = clock_source_select_pin_i;
        raw_pins.loff_p = loff_comp_p_i;
        raw_pins.loff_n = loff_comp_n_i;
    end
    ccc_pin_sync #(
        .WIDTH($bits(ccc_pins_t)),
        .RST_VAL(CCC_PINS_IDLE)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .pin_i(raw_pins),
        .clean_o(pins_flat)
    );
    assign pins = ccc_pins_t'(pins_flat);
    // ============================================================
    // Edge detection on clean pins
    logic sclk_q, start_q; // Previous clean values
    logic sclk_rise, sclk_fall, start_rise;
    always_comb begin
        sclk_rise = pins.sclk & ~sclk_q;
        sclk_fall = ~pins.sclk & sclk_q;
        start_rise = pins.start & ~start_q;
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            sclk_q <= pins.sclk;
            start_q <= pins.start;
        end
    end
    // ============================================================
    // Register file and serial engine
    logic [7:0] cfg_q, cfg_d; // conversion_and_comparator_config
    logic [7:0] pos_fb_q, pos_fb_d; // positive_feedback_select
    logic [7:0] neg_fb_q, neg_fb_d; // negative_feedback_select
    logic [7:0] clk_ctrl_q, clk_ctrl_d; // Clock output control
    logic [7:0] in_sr_q, in_sr_d; // Incoming byte
    logic [2:0] bit_cnt_q, bit_cnt_d; // Bit within byte
    logic first_q, first_d; // Next byte is the command byte
    logic [7:0] cmd_q, cmd_d; // Held command byte
    logic [FRAME_W-1:0] out_sr_q, out_sr_d; // Outgoing frame
    logic dout_q, dout_d;
    logic dout_oe_q, dout_oe_d;
    logic sample_cmd; // Sample read decoded this cycle
    logic [FRAME_W-1:0] frame_q; // Latched status plus samples
    logic [7:0] byte_in; // Byte completed this cycle
    logic [7:0] rdata; // Register read data

    // Read multiplexer; unmapped addresses read as zero
    always_comb begin
        case (byte_in[4:0])
            CCC_ADDR_CFG: rdata = cfg_q;
            CCC_ADDR_POS_FB: rdata = pos_fb_q;
            CCC_ADDR_NEG_FB: rdata = neg_fb_q;
            CCC_ADDR_CLK_CTRL: rdata = clk_ctrl_q;
            default: rdata = 8'h00;
        endcase
    end

    // Byte assembly, command decode and shift-out
    always_comb begin
        in_sr_d = in_sr_q;
        bit_cnt_d = bit_cnt_q;
        first_d = first_q;
        cmd_d = cmd_q;
        out_sr_d = out_sr_q;
        dout_d = dout_q;
        cfg_d = cfg_q;
        pos_fb_d = pos_fb_q;
        neg_fb_d = neg_fb_q;
        clk_ctrl_d = clk_ctrl_q;
        sample_cmd = 1'b0;
        byte_in = {in_sr_q[6:0], pins.din};
        dout_oe_d = ~pins.cs_n; // Float the shared line when deselected [RULE9]
        if (pins.cs_n) begin
            // Deselected: frame state returns to its start
            bit_cnt_d = 3'h0;
            first_d = 1'b1;
            dout_d = 1'b0;
        end else if (sclk_rise) begin
            // Shift next bit out on the rising edge
            dout_d = out_sr_q[FRAME_W-1];
            out_sr_d = {out_sr_q[FRAME_W-2:0], 1'b0};
        end else if (sclk_fall) begin
            // Capture on the falling edge
            in_sr_d = byte_in;
            bit_cnt_d = bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
                first_d = 1'b0;
                if (first_q) begin
                    cmd_d = byte_in;
                    if (byte_in == CCC_CMD_SAMPLE) begin
                        out_sr_d = frame_q; // Status and samples [RULE4]
                        sample_cmd = 1'b1;
                    end else if (byte_in[7:5] == CCC_OP_READ) begin
                        out_sr_d = {rdata, {(FRAME_W-8){1'b0}}};
                    end
                end else if (cmd_q[7:5] == CCC_OP_WRITE) begin
                    // Write data byte to the addressed register
                    case (cmd_q[4:0])
                        CCC_ADDR_CFG: cfg_d = byte_in; // [RULE1]
                        CCC_ADDR_POS_FB: pos_fb_d = byte_in;
                        CCC_ADDR_NEG_FB: neg_fb_d = byte_in;
                        CCC_ADDR_CLK_CTRL: clk_ctrl_d = byte_in;
                        default: ;
                    endcase
                end
            end
        end
    end

    // Register the serial engine and register file
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_q <= CCC_CFG_RESET; // [RULE1]
            pos_fb_q <= CCC_FB_RESET;
            neg_fb_q <= CCC_FB_RESET;
            clk_ctrl_q <= CCC_CLK_CTRL_RESET;
            in_sr_q <= 8'h00;
            bit_cnt_q <= 3'h0;
            first_q <= 1'b1;
            cmd_q <= 8'h00;
            out_sr_q <= '0;
            dout_q <= 1'b0;
            dout_oe_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            pos_fb_q <= pos_fb_d;
            neg_fb_q <= neg_fb_d;
            clk_ctrl_q <= clk_ctrl_d;
            in_sr_q <= in_sr_d;
            bit_cnt_q <= bit_cnt_d;
            first_q <= first_d;
            cmd_q <= cmd_d;
            out_sr_q <= out_sr_d;
            dout_q <= dout_d;
            dout_oe_q <= dout_oe_d;
        end
    end
    // ============================================================
    // Conversion sequencer
    ccc_state_t state_q, state_d;
    logic [31:0] cnt_q, cnt_d; // Cycles into the current conversion
    logic sample_ready_indication_n_q, sample_ready_indication_n_d; // sample_ready_indication, active low
    logic [FRAME_W-1:0] frame_d;
    logic comp_en; // Comparators enabled
    logic single; // Single-shot mode
    logic done;
    always_comb begin
        comp_en = cfg_q[CCC_BIT_COMP_EN]; // [RULE3]
        single = cfg_q[CCC_BIT_SINGLE_SHOT]; // [RULE2]
        done = (state_q == CCC_ST_CONV) && (cnt_q == 32'(CONV_CYCLES - 1));
        state_d = state_q;
        cnt_d = cnt_q;
        sample_ready_indication_n_d = sample_ready_indication_n_q;
        frame_d = frame_q;
        if (sample_cmd) begin
            sample_ready_indication_n_d = 1'b1; // Data being read, ready withdrawn
        end
        case (state_q)
            CCC_ST_IDLE: begin
                if (start_rise) begin
                    state_d = CCC_ST_CONV; // Fixed latency from start [RULE7]
                    cnt_d = 32'h0;
                end
            end
            CCC_ST_CONV: begin
                if (start_rise) begin
                    cnt_d = 32'h0; // Restart keeps devices aligned [RULE7]
                end else if (done) begin
                    sample_ready_indication_n_d = 1'b0; // Ready wins over a withdraw
                    frame_d = {CCC_STATUS_TAG, pins.loff_p & {8{comp_en}},
                               pins.loff_n & {8{comp_en}}, 4'h0,
                               sample_data_i}; // [RULE4]
                    cnt_d = 32'h0;
                    if (single) begin
                        state_d = CCC_ST_HALT; // One conversion then halt [RULE10]
                    end else if (!pins.start) begin
                        state_d = CCC_ST_IDLE; // Continuous stops with start low [RULE2]
                    end
                end else begin
                    cnt_d = cnt_q + 32'h1;
                end
            end
            CCC_ST_HALT: begin
                if (start_rise) begin
                    state_d = CCC_ST_CONV; // Next start event [RULE10]
                    cnt_d = 32'h0;
                end
            end
            default: state_d = CCC_ST_IDLE;
        endcase
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= CCC_ST_IDLE;
            cnt_q <= 32'h0;
            sample_ready_indication_n_q <= 1'b1;
            frame_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sample_ready_indication_n_q <= sample_ready_indication_n_d;
            frame_q <= frame_d;
        end
    end
    // ============================================================
    // Static control outputs
    logic comp_en_q, clk_out_en_q;
    logic [7:0] pos_out_q, neg_out_q;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            comp_en_q <= 1'b0;
            clk_out_en_q <= 1'b0;
            pos_out_q <= 8'h00;
            neg_out_q <= 8'h00;
        end else begin
            comp_en_q <= comp_en; // [RULE3]
            // Clock master only with select pin high and enable bit set [RULE6]
            clk_out_en_q <= pins.clk_sel & clk_ctrl_q[CCC_BIT_CLK_OUT_EN];
            pos_out_q <= pos_fb_q; // Only selected electrodes feed back [RULE8]
            neg_out_q <= neg_fb_q; // [RULE8]
        end
    end
    assign dout_o = dout_q;
    assign dout_oe_o = dout_oe_q;
    assign sample_ready_indication_n_o = sample_ready_indication_n_q;
    assign clk_out_en_o = clk_out_en_q;
    assign electrode_detach_comparator_enable_o = comp_en_q;
    assign positive_feedback_select_o = pos_out_q;
    assign negative_feedback_select_o = neg_out_q;
endmodule // ccc_top

// *** verification/ccc_host_model.sv ***
// Host serial controller model: one select line, shared clock and data lines.
// Assumes the device takes data on clock fall and drives it on clock rise.
`timescale 1ns/1ps
module ccc_host_model (
    // Clock
    input wire logic ref_clk_i,
    // Serial lines
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o,
    input wire logic dout_i,
    input wire logic dout_oe_i
);
    // ============================================================
    // Line resolution
    logic idle_q = 1'b0; // Changing level seen on a released line
    logic line; // Data-out line as the host sees it
    // Released line shows no stale value
    always @(posedge ref_clk_i) idle_q <= ~idle_q;
    assign line = dout_oe_i ? dout_i : idle_q;
    // Idle levels: deselected, clock low
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o = 1'b0;
    end
    // ============================================================
    // Bus tasks
    // Wait edges, then step just off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    // Select or deselect this device; other lines are shared
    task automatic sel(input logic en);
        tick(8);
        cs_n_o = ~en;
        tick(8);
    endtask
    // One byte each way, MSB first, each clock level 8 reference clocks
    // Data changes mid-low so it still stands when the device sees the fall
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            din_o = tx[i];
            tick(4);
            sclk_o = 1'b1;
            tick(8);
            rx[i] = line;
            sclk_o = 1'b0;
            tick(4);
        end
    endtask
endmodule // ccc_host_model

// *** verification/ccc_top_sva.sv ***
// Checker for the conversion mode config block, watching top-level ports.
// Assumes one reference clock and the asynchronous active-high reset.
`timescale 1ns/1ps
module ccc_top_sva #(
    parameter int CONV_CYCLES = 20
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Watched pins
    input wire logic cs_n_i,
    input wire logic dout_o,
    input wire logic dout_oe_o,
    input wire logic start_i,
    input wire logic clock_source_select_pin_i,
    input wire logic sample_ready_indication_n_o,
    input wire logic clk_out_en_o,
    input wire logic electrode_detach_comparator_enable_o,
    input wire logic [7:0] positive_feedback_select_o,
    input wire logic [7:0] negative_feedback_select_o
);
    // ============================================================
    // Latency bookkeeping
    localparam int LAT_LO = CONV_CYCLES + 1; // Earliest ready after start pin
    localparam int LAT_HI = CONV_CYCLES + 6; // Latest, with synchronizer slack
    logic start_q, start_d; // Previous start pin level
    logic armed_q, armed_d; // Start seen, ready not yet low
    logic [31:0] cnt_q, cnt_d; // Cycles since start pin rose
    // Next values of the bookkeeping
    always_comb begin
        start_d = start_i;
        armed_d = armed_q;
        cnt_d = (cnt_q == 32'hFFFF_FFFF) ? cnt_q : cnt_q + 32'h0000_0001;
        if (start_i && !start_q) begin
            cnt_d = 32'h0000_0000;
            armed_d = 1'b1;
        end else if (!sample_ready_indication_n_o) begin
            armed_d = 1'b0;
        end
    end
    // Registers only
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            start_q <= 1'b0;
            armed_q <= 1'b0;
            cnt_q <= 32'h0000_0000;
        end else begin
            start_q <= start_d;
            armed_q <= armed_d;
            cnt_q <= cnt_d;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // ============================================================
    // Properties
    property p_oe_off;
        cs_n_i [*8] |-> !dout_oe_o;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("data out driven while deselected");
    property p_dout_zero;
        !dout_oe_o |-> !dout_o;
    endproperty
    a_dout_zero: assert property (p_dout_zero) else $error("data out not low when released");
    property p_oe_on;
        !cs_n_i [*8] |-> dout_oe_o;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("selected device not driving");
    property p_rst_vals;
        $fell(rst_i) |-> {electrode_detach_comparator_enable_o, positive_feedback_select_o,
            negative_feedback_select_o} == 17'h00000;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("register outputs not cleared");
    property p_lat;
        $fell(sample_ready_indication_n_o) && armed_q |-> cnt_q >= LAT_LO && cnt_q <= LAT_HI;
    endproperty
    a_lat: assert property (p_lat) else $error("start to ready latency wrong");
    property p_rdy_hold;
        $fell(sample_ready_indication_n_o) |-> !sample_ready_indication_n_o [*8];
    endproperty
    a_rdy_hold: assert property (p_rdy_hold) else $error("ready withdrawn too early");
    property p_clk_out;
        !clock_source_select_pin_i [*8] |-> !clk_out_en_o;
    endproperty
    a_clk_out: assert property (p_clk_out) else $error("clock out without select pin");
    property p_cfg_change;
        $changed(electrode_detach_comparator_enable_o) || $changed(positive_feedback_select_o)
            || $changed(negative_feedback_select_o) |-> dout_oe_o;
    endproperty
    a_cfg_change: assert property (p_cfg_change) else $error("config moved while idle");
    // Main scenarios reached
    c_ready: cover property ($fell(sample_ready_indication_n_o));
    c_clk_out: cover property ($rose(clk_out_en_o));
    c_comp_on: cover property ($rose(electrode_detach_comparator_enable_o));
endmodule // ccc_top_sva
bind ccc_top ccc_top_sva #(.CONV_CYCLES(CONV_CYCLES)) u_ccc_top_sva (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .cs_n_i(cs_n_i),
    .dout_o(dout_o),
    .dout_oe_o(dout_oe_o),
    .start_i(start_i),
    .clock_source_select_pin_i(clock_source_select_pin_i),
    .sample_ready_indication_n_o(sample_ready_indication_n_o),
    .clk_out_en_o(clk_out_en_o),
    .electrode_detach_comparator_enable_o(electrode_detach_comparator_enable_o),
    .positive_feedback_select_o(positive_feedback_select_o),
    .negative_feedback_select_o(negative_feedback_select_o)
);

// *** verification/tb_top.sv ***
// Testbench for the conversion mode config block, driven through the host model.
// Assumes a shortened conversion of 20 clocks and two channels in the frame.
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        compares++; \
        if ((g) !== (e)) begin \
            bad_count++; \
            $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); \
        end \
    end
module tb_top;
    import ccc_pkg::*;
    // ============================================================
    // Signals
    localparam int NCH = 2; // Channels in the frame
    localparam int CONV = 20; // Clocks per conversion
    logic ref_clk_i, rst_i, sclk, cs_n, din, dout, dout_oe, start, clk_sel;
    logic rdy_n, clk_en, comp_en;
    logic [7:0] loff_p, loff_n, pos_fb, neg_fb;
    logic [NCH*24-1:0] samples; // Core sample words
    logic [79:0] got; // Bytes read back, last in the low byte
    logic [7:0] vals [3] = '{8'hF5, 8'h08, 8'h02}; // Config values tried
    int bad_count = 0;
    int compares = 0;
    int lat0, lat1;
    ccc_top #(.N_CH(NCH), .CONV_CYCLES(CONV)) u_ccc_top (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe),
        .start_i(start), .clock_source_select_pin_i(clk_sel), .sample_ready_indication_n_o(rdy_n),
        .clk_out_en_o(clk_en), .sample_data_i(samples), .loff_comp_p_i(loff_p),
        .loff_comp_n_i(loff_n), .electrode_detach_comparator_enable_o(comp_en),
        .positive_feedback_select_o(pos_fb), .negative_feedback_select_o(neg_fb));
    ccc_host_model u_ccc_host_model (.ref_clk_i(ref_clk_i), .sclk_o(sclk), .cs_n_o(cs_n),
        .din_o(din), .dout_i(dout), .dout_oe_i(dout_oe));
    // 40 MHz reference clock
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    // ============================================================
    // Tasks
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    // Verdict and end of run
    task automatic stop_test();
        if (bad_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // One select period: command byte, then n data bytes each way
    task automatic xact(input logic [7:0] c, input logic [7:0] w, input int n);
        logic [7:0] b;
        u_ccc_host_model.sel(1'b1);
        u_ccc_host_model.xfer(c, b);
        for (int i = 0; i < n; i++) begin
            u_ccc_host_model.xfer(w, b);
            got = {got[71:0], b};
        end
        u_ccc_host_model.sel(1'b0);
    endtask
    // Bounded wait for ready low, counting clocks
    task automatic wait_rdy(output int n);
        n = 0;
        while (rdy_n !== 1'b0) begin
            tick(1);
            n++;
            if (n > 500) begin
                bad_count++;
                stop_test();
            end
        end
    endtask
    // ============================================================
    // Main sequence
    initial begin
        rst_i = 1'b1;
        start = 1'b0;
        clk_sel = 1'b0;
        loff_p = 8'hA5;
        loff_n = 8'h3C;
        samples = 48'h123456ABCDEF;
        tick(8);
        rst_i = 1'b0;
        tick(6);
        `CHK(dout_oe, 1'b0)
        xact({CCC_OP_READ, CCC_ADDR_CFG}, 8'h00, 1);
        `CHK(got[7:0], CCC_CFG_RESET)
        foreach (vals[i]) begin
            xact({CCC_OP_WRITE, CCC_ADDR_CFG}, vals[i], 1);
            xact({CCC_OP_READ, CCC_ADDR_CFG}, 8'h00, 1);
            `CHK(got[7:0], vals[i])
            `CHK(comp_en, vals[i][1])
        end
        xact({CCC_OP_READ, 5'h10}, 8'h00, 1);
        `CHK(got[7:0], 8'h00)
        xact({CCC_OP_WRITE, CCC_ADDR_POS_FB}, 8'h07, 1);
        xact({CCC_OP_WRITE, CCC_ADDR_NEG_FB}, 8'h70, 1);
        `CHK({pos_fb, neg_fb}, 16'h0770)
        clk_sel = 1'b1;
        xact({CCC_OP_WRITE, CCC_ADDR_CLK_CTRL}, 8'h20, 1);
        `CHK(clk_en, 1'b1)
        clk_sel = 1'b0;
        tick(8);
        `CHK(clk_en, 1'b0)
        // Continuous mode with comparators on
        start = 1'b1;
        wait_rdy(lat0);
        `CHK((lat0 >= CONV + 2 && lat0 <= CONV + 6), 1'b1)
        xact(CCC_CMD_SAMPLE, 8'h00, 3 + NCH * 3);
        `CHK(got[71:48], {4'hC, loff_p, loff_n, 4'h0})
        `CHK(got[47:0], samples)
        wait_rdy(lat1);
        `CHK((lat1 <= CONV + 6), 1'b1)
        start = 1'b0;
        tick(CONV * 3);
        // Single-shot mode with comparators off; read once first to withdraw the stale ready
        xact({CCC_OP_WRITE, CCC_ADDR_CFG}, 8'h08, 1);
        xact(CCC_CMD_SAMPLE, 8'h00, 3 + NCH * 3);
        start = 1'b1;
        wait_rdy(lat1);
        `CHK(lat1, lat0)
        xact(CCC_CMD_SAMPLE, 8'h00, 3 + NCH * 3);
        `CHK(got[71:48], 24'hC00000)
        tick(CONV * 5);
        `CHK(rdy_n, 1'b1)
        start = 1'b0;
        // Second reset in mid-run
        rst_i = 1'b1;
        tick(2);
        rst_i = 1'b0;
        tick(6);
        xact({CCC_OP_READ, CCC_ADDR_CFG}, 8'h00, 1);
        `CHK(got[7:0], CCC_CFG_RESET)
        stop_test();
    end
endmodule // tb_top
